// File: verilog/duc_update_ctrl.sv
// Overview of operation
// - each channel takes a 12-bit unsigned code
// - codes right-aligned; bipolar uses offset binary
// - channel count parameter: two, four or six
// - auto mode: high byte write updates output
// - auto mode entered by a read
// - simultaneous: preload all, one read updates all
// - 64-byte region, first 16 bytes dac control
// - 16 reserved, 4 digital I/O, 28 reserved
// - separate 256-byte calibration data region
// - control on bar two, calibration bar three
// - fixed vendor id, device id per build
// - addresses set only by enumeration
// - reset: outputs restricted, simultaneous mode, preload undefined
// - read 8 updates, simul; A updates, auto
// - read 2 in simul: auto, no update
// - read E restricts to 15%, F releases
`timescale 1ns/1ps
`default_nettype none
`include "duc_defs.svh"

module duc_update_ctrl #(
  parameter int NCH = 6
) (
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire duc_pkg::duc_io_req_type   io_req,
  output logic                           io_ack,
  output logic [7:0]                     io_rdata,
  output duc_pkg::duc_dio_req_type       dio_req,
  input  wire logic [7:0]                dio_rdata,
  output logic [NCH-1:0][11:0]           dac_code,
  output logic [NCH-1:0][11:0]           dac_level,
  output logic                           restrict_on,
  output logic                           simul_mode,
  output logic [15:0]                    vendor_id,
  output logic [15:0]                    device_id,
  output logic [15:0]                    ctrl_bar_size,
  output logic [15:0]                    cal_bar_size
);

  // build must be one of the three documented channel counts
  if (NCH != 2 && NCH != 4 && NCH != 6)
  begin : g_bad_nch
    $error("channel count must be 2, 4 or 6");
  end

  // identity and region sizes are constants; no strap or switch sets a base
  assign vendor_id     = `DUC_VENDOR_ID;
  assign device_id     = (NCH == 2) ? `DUC_DEVICE_ID_2CH :
                         (NCH == 4) ? `DUC_DEVICE_ID_4CH : `DUC_DEVICE_ID_6CH;
  assign ctrl_bar_size = `DUC_CTRL_SIZE;
  assign cal_bar_size  = `DUC_CAL_SIZE;

  // region decode: bar slot first, then offset within the 64-byte window
  logic       hit_ctrl;
  logic       hit_cal;
  logic       hit_dac;
  logic       hit_dio;
  logic       rd_dac;
  logic       wr_dac;
  logic [3:0] dac_ofs;
  assign hit_ctrl = io_req.valid && (io_req.bar_sel == `DUC_BAR_CTRL);
  assign hit_cal  = io_req.valid && (io_req.bar_sel == `DUC_BAR_CAL);
  assign hit_dac  = hit_ctrl && (io_req.addr[5:4] == `DUC_AREA_DAC);
  assign hit_dio  = hit_ctrl && (io_req.addr[5:2] == `DUC_AREA_DIO);
  assign dac_ofs  = io_req.addr[3:0];
  assign rd_dac   = hit_dac && !io_req.write;
  assign wr_dac   = hit_dac && io_req.write;

  // read commands; reads carry no data, only side effects
  logic cmd_simul;
  logic cmd_auto;
  logic cmd_upd_simul;
  logic cmd_upd_auto;
  logic cmd_restrict;
  logic cmd_release;
  logic cmd_update;
  assign cmd_simul     = rd_dac && (dac_ofs == `DUC_RD_SIMUL);
  assign cmd_auto      = rd_dac && (dac_ofs == `DUC_RD_AUTO);
  assign cmd_upd_simul = rd_dac && (dac_ofs == `DUC_RD_UPD_SIMUL);
  assign cmd_upd_auto  = rd_dac && (dac_ofs == `DUC_RD_UPD_AUTO);
  assign cmd_restrict  = rd_dac && (dac_ofs == `DUC_RD_RESTRICT);
  assign cmd_release   = rd_dac && (dac_ofs == `DUC_RD_RELEASE);
  assign cmd_update    = cmd_upd_simul || cmd_upd_auto;

  // update mode and output restriction
  duc_pkg::duc_mode_type mode_ff;
  duc_pkg::duc_mode_type nxt_mode;
  logic                  restrict_ff;
  logic                  nxt_restrict;
  assign nxt_mode = (cmd_simul || cmd_upd_simul) ? duc_pkg::DUC_MODE_SIMUL :
                    (cmd_auto || cmd_upd_auto)   ? duc_pkg::DUC_MODE_AUTO : mode_ff;
  assign nxt_restrict = cmd_restrict ? 1'b1 : (cmd_release ? 1'b0 : restrict_ff);

  // power-up leaves outputs clamped and waiting for a simultaneous update
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mode_ff     <= duc_pkg::DUC_MODE_SIMUL;
      restrict_ff <= 1'b1;
    end
    else
    begin
      mode_ff     <= nxt_mode;
      restrict_ff <= nxt_restrict;
    end
  end

  assign simul_mode  = (mode_ff == duc_pkg::DUC_MODE_SIMUL);
  assign restrict_on = restrict_ff;

  // one double-buffered channel per slot; absent slots are simply not built
  logic [NCH-1:0][11:0] preload_ff;
  logic [NCH-1:0][11:0] inner_ff;
  logic [NCH-1:0][11:0] level_ff;
  for (genvar ch = 0; ch < NCH; ch++)
  begin : g_ch
    logic        wr_lo;
    logic        wr_hi;
    logic        hi_load;
    logic [11:0] nxt_inner;
    logic [15:0] scaled;
    assign wr_lo   = wr_dac && (dac_ofs[3:1] == 3'(ch)) && !dac_ofs[0];
    assign wr_hi   = wr_dac && (dac_ofs[3:1] == 3'(ch)) && dac_ofs[0];
    // the high byte only moves the output in auto mode
    assign hi_load = wr_hi && (mode_ff == duc_pkg::DUC_MODE_AUTO);
    assign nxt_inner = cmd_update ? preload_ff[ch] :
                       hi_load    ? {io_req.wdata[3:0], preload_ff[ch][7:0]} :
                                    inner_ff[ch];
    // restricted level is 15% of the programmed value, like a lowered reference
    assign scaled  = (16'(inner_ff[ch]) * `DUC_RESTRICT_NUM) / `DUC_RESTRICT_DEN;

    // preload keeps its power-up contents; software must load it first
    always_ff @(posedge ref_clk)
    begin
      if (wr_lo)
        preload_ff[ch][7:0] <= io_req.wdata;
      if (wr_hi)
        preload_ff[ch][11:8] <= io_req.wdata[3:0];
    end

    always_ff @(posedge ref_clk)
    begin
      if (reset)
      begin
        inner_ff[ch] <= `DUC_CODE_RESET;
        level_ff[ch] <= `DUC_CODE_RESET;
      end
      else
      begin
        inner_ff[ch] <= nxt_inner;
        level_ff[ch] <= restrict_ff ? scaled[11:0] : inner_ff[ch];
      end
    end
  end

  assign dac_code  = inner_ff;
  assign dac_level = level_ff;

  // calibration bytes; a small array, not cleared by reset
  logic [7:0] cal_mem [256];
  logic [7:0] cal_rd;
  assign cal_rd = cal_mem[io_req.addr];

  always_ff @(posedge ref_clk)
  begin
    if (hit_cal && io_req.write)
      cal_mem[io_req.addr] <= io_req.wdata;
  end

  // digital I/O accesses pass straight to that circuit in the same cycle
  assign dio_req.valid = hit_dio;
  assign dio_req.write = io_req.write;
  assign dio_req.addr  = io_req.addr[1:0];
  assign dio_req.wdata = io_req.wdata;

  // every access to either region is claimed; reserved bytes read as zero
  logic [7:0] nxt_rdata;
  logic       ack_ff;
  logic [7:0] rdata_ff;
  assign nxt_rdata = (hit_cal && !io_req.write) ? cal_rd :
                     (hit_dio && !io_req.write) ? dio_rdata : `DUC_RDATA_ZERO;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= `DUC_RDATA_ZERO;
    end
    else
    begin
      ack_ff   <= hit_ctrl || hit_cal;
      rdata_ff <= nxt_rdata;
    end
  end

  assign io_ack   = ack_ff;
  assign io_rdata = rdata_ff;

  // ---- checks ----
  default clocking cb @(posedge ref_clk); endclocking

  logic wr_hi0;
  logic wr_lo0;
  assign wr_hi0 = wr_dac && (dac_ofs == 4'h1);
  assign wr_lo0 = wr_dac && (dac_ofs == 4'h0);

  property p_reset_state;
    reset |=> simul_mode && restrict_on && (dac_code[0] == `DUC_CODE_RESET);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");

  property p_auto_hi;
    disable iff (reset)
    (wr_hi0 && !simul_mode)
      |=> dac_code[0] == {$past(io_req.wdata[3:0]), $past(preload_ff[0][7:0])};
  endproperty
  a_auto_hi: assert property (p_auto_hi) else $error("auto high write missed");

  property p_lo_quiet;
    disable iff (reset)
    (wr_lo0 && !cmd_update) |=> $stable(dac_code[0]);
  endproperty
  a_lo_quiet: assert property (p_lo_quiet) else $error("low byte moved output");

  property p_simul_hold;
    disable iff (reset)
    (wr_hi0 && simul_mode) |=> $stable(dac_code[0]);
  endproperty
  a_simul_hold: assert property (p_simul_hold) else $error("simul mode leaked");

  property p_upd_simul;
    disable iff (reset)
    cmd_upd_simul |=> simul_mode && (dac_code[NCH-1] == $past(preload_ff[NCH-1]));
  endproperty
  a_upd_simul: assert property (p_upd_simul) else $error("offset 8 update wrong");

  property p_upd_auto;
    disable iff (reset)
    cmd_upd_auto |=> !simul_mode && (dac_code[0] == $past(preload_ff[0]));
  endproperty
  a_upd_auto: assert property (p_upd_auto) else $error("offset A update wrong");

  property p_to_auto;
    disable iff (reset)
    (cmd_auto && simul_mode) |=> !simul_mode && $stable(dac_code);
  endproperty
  a_to_auto: assert property (p_to_auto) else $error("offset 2 misbehaved");

  property p_restrict;
    disable iff (reset)
    (cmd_restrict && !io_req.write) |=> restrict_on ##1
      (dac_level[0] == 12'((16'($past(dac_code[0])) * `DUC_RESTRICT_NUM) / `DUC_RESTRICT_DEN));
  endproperty
  a_restrict: assert property (p_restrict) else $error("restrict level wrong");

  property p_release;
    disable iff (reset)
    (cmd_release ##1 !cmd_restrict) |=> (dac_level[0] == $past(dac_code[0]));
  endproperty
  a_release: assert property (p_release) else $error("release level wrong");

  property p_reserved_zero;
    disable iff (reset)
    (hit_ctrl && !hit_dac && !hit_dio) |=> io_ack && (io_rdata == `DUC_RDATA_ZERO);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved byte not zero");

  property p_cal_read;
    disable iff (reset)
    (hit_cal && !io_req.write) |=> io_ack && (io_rdata == $past(cal_rd));
  endproperty
  a_cal_read: assert property (p_cal_read) else $error("calibration read wrong");

  // a reset must also clamp the last channel and drop any pending answer
  property p_reset_level;
    reset |=> !io_ack && (dac_level[NCH-1] == `DUC_CODE_RESET);
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("reset level not safe");

  // released outputs follow the programmed code with one cycle of lag
  property p_level_free;
    disable iff (reset)
    !restrict_on |=> dac_level[NCH-1] == $past(dac_code[NCH-1]);
  endproperty
  a_level_free: assert property (p_level_free) else $error("unrestricted level wrong");

  // digital I/O accesses pass through unchanged in the request cycle
  property p_dio_pass;
    disable iff (reset)
    hit_dio |-> dio_req.valid && (dio_req.addr == io_req.addr[1:0]) && (dio_req.wdata == io_req.wdata);
  endproperty
  a_dio_pass: assert property (p_dio_pass) else $error("dio access not forwarded");

  // nothing outside the four dio bytes may reach that circuit
  property p_dio_quiet;
    disable iff (reset)
    (io_req.valid && !hit_dio) |-> !dio_req.valid;
  endproperty
  a_dio_quiet: assert property (p_dio_quiet) else $error("dio access leaked");

  // slots other than the two mapped bars are never claimed
  property p_other_bar;
    disable iff (reset)
    (io_req.valid && !hit_ctrl && !hit_cal) |=> !io_ack;
  endproperty
  a_other_bar: assert property (p_other_bar) else $error("foreign bar acked");

  c_auto_update:  cover property (disable iff (reset) cmd_upd_auto ##[1:20] wr_hi0);
  c_simul_update: cover property (disable iff (reset) wr_lo0 ##[1:10] wr_hi0 ##[1:10] cmd_upd_simul);
  c_release:      cover property (disable iff (reset) cmd_update ##[1:20] cmd_release);
  c_dio_access:   cover property (disable iff (reset) hit_dio);
  c_cal_access:   cover property (disable iff (reset) (hit_cal && io_req.write) ##[1:10] (hit_cal && !io_req.write));

endmodule

`default_nettype wire

// File: verilog/duc_defs.svh
`ifndef DUC_DEFS_SVH
`define DUC_DEFS_SVH

// base address register slots that carry the two I/O regions
`define DUC_BAR_CTRL       3'h2
`define DUC_BAR_CAL        3'h3
// region sizes in bytes, reported to enumeration
`define DUC_CTRL_SIZE      16'h0040
`define DUC_CAL_SIZE       16'h0100
// control region areas (offset bits [5:4] or [5:2])
`define DUC_AREA_DAC       2'h0
`define DUC_AREA_DIO       4'h8
// read command offsets inside the dac area
`define DUC_RD_SIMUL       4'h0
`define DUC_RD_AUTO        4'h2
`define DUC_RD_UPD_SIMUL   4'h8
`define DUC_RD_UPD_AUTO    4'hA
`define DUC_RD_RESTRICT    4'hE
`define DUC_RD_RELEASE     4'hF
// code range and restriction scaling (fifteen percent of the programmed code)
`define DUC_CODE_MAX       12'hFFF
`define DUC_CODE_RESET     12'h000
`define DUC_RESTRICT_NUM   16'h000F
`define DUC_RESTRICT_DEN   16'h0064
`define DUC_RDATA_ZERO     8'h00
// identity codes: arbitrary neutral values
`define DUC_VENDOR_ID      16'h1AB0
`define DUC_DEVICE_ID_2CH  16'h0102
`define DUC_DEVICE_ID_4CH  16'h0104
`define DUC_DEVICE_ID_6CH  16'h0106

`endif

// File: verilog/duc_pkg.sv
package duc_pkg;

  // one byte-wide I/O access from the bus target, already matched to a bar
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] bar_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } duc_io_req_type;

  // access forwarded to the digital I/O circuit
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] addr;
    logic [7:0] wdata;
  } duc_dio_req_type;

  typedef enum logic {
    DUC_MODE_SIMUL,
    DUC_MODE_AUTO
  } duc_mode_type;

endpackage

// File: verification/duc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the byte-wide I/O path: one access per call, answer taken a cycle later
module duc_host_model (
  input  wire logic                     ref_clk,
  output var  duc_pkg::duc_io_req_type  io_req,
  input  wire logic                     io_ack,
  input  wire logic [7:0]               io_rdata
);
  initial io_req = '0;

  // request stands for one edge; afterwards fields are inverted so stale values never match
  task automatic access(input logic wr, input logic [2:0] bar, input logic [7:0] addr,
                        input logic [7:0] wd, output logic ack, output logic [7:0] rd);
    @(posedge ref_clk);
    #1 io_req = '{valid: 1'b1, write: wr, bar_sel: bar, addr: addr, wdata: wd};
    @(posedge ref_clk);
    #1 io_req = {1'b0, ~io_req[19:0]};
    ack = io_ack;
    rd = io_rdata;
  endtask

  // right-aligned code, low byte first so the high byte write commits it in auto mode
  task automatic put_code(input int ch, input logic [11:0] code);
    logic       a;
    logic [7:0] r;
    access(1'b1, 3'h2, 8'(2 * ch), code[7:0], a, r);
    access(1'b1, 3'h2, 8'(2 * ch + 1), {4'h0, code[11:8]}, a, r);
  endtask
endmodule

`default_nettype wire

// File: verification/dac_update_control_pci_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "duc_defs.svh"

module dac_update_control_pci_test;
  logic                      ref_clk;
  logic                      reset;
  logic [7:0]                dio_rdata;
  duc_pkg::duc_io_req_type   io_req;
  duc_pkg::duc_dio_req_type  dio_req;
  logic                      io_ack;
  logic [7:0]                io_rdata;
  logic [5:0][11:0]          dac_code;
  logic [5:0][11:0]          dac_level;
  logic                      restrict_on;
  logic                      simul_mode;
  logic [15:0]               vendor_id;
  logic [15:0]               device_id;
  logic [15:0]               ctrl_bar_size;
  logic [15:0]               cal_bar_size;
  logic [5:0][11:0]          exp_code;
  logic                      ack;
  logic [7:0]                rd;
  int                        n_errors = 0;
  int                        num_checks = 0;
  int                        cycles = 0;
  duc_pkg::duc_dio_req_type  last_dio;

  duc_update_ctrl #(.NCH(6)) u_duc_update_ctrl (.ref_clk(ref_clk), .reset(reset),
    .io_req(io_req), .io_ack(io_ack), .io_rdata(io_rdata), .dio_req(dio_req),
    .dio_rdata(dio_rdata), .dac_code(dac_code), .dac_level(dac_level),
    .restrict_on(restrict_on), .simul_mode(simul_mode), .vendor_id(vendor_id),
    .device_id(device_id), .ctrl_bar_size(ctrl_bar_size), .cal_bar_size(cal_bar_size));

  duc_host_model u_duc_host_model (.ref_clk(ref_clk), .io_req(io_req), .io_ack(io_ack),
    .io_rdata(io_rdata));

  // capture what the design hands to the digital I/O circuit while a request stands
  always @(posedge ref_clk)
  begin
    if (dio_req.valid)
      last_dio <= dio_req;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic acc(input logic wr, input logic [2:0] bar, input logic [7:0] addr,
                     input logic [7:0] wd);
    u_duc_host_model.access(wr, bar, addr, wd, ack, rd);
  endtask

  // command reads in the dac area are acked and return zero
  task automatic cmd(input logic [7:0] addr);
    acc(1'b0, 3'h2, addr, 8'h00);
    chk("cmd ack", 16'(ack), 16'h0001);
    chk("cmd data", 16'(rd), 16'h0000);
  endtask

  task automatic codes(input string what);
    for (int ch = 0; ch < 6; ch++)
      chk(what, 16'(dac_code[ch]), 16'(exp_code[ch]));
  endtask

  task automatic t_reset;
    exp_code = '0;
    chk("simul", 16'(simul_mode), 16'h0001);
    chk("restrict", 16'(restrict_on), 16'h0001);
    codes("reset code");
    chk("ctrl size", ctrl_bar_size, 16'h0040);
    chk("cal size", cal_bar_size, 16'h0100);
    chk("vendor", vendor_id, `DUC_VENDOR_ID);
    chk("device", device_id, `DUC_DEVICE_ID_6CH);
    $display("reset test done");
  endtask

  // preloads must stay hidden until the single update read
  task automatic t_simul;
    for (int ch = 0; ch < 6; ch++)
      u_duc_host_model.put_code(ch, (ch == 0) ? 12'hFFF : 12'(ch * 12'h2A5));
    codes("code before update");
    for (int ch = 0; ch < 6; ch++)
      exp_code[ch] = (ch == 0) ? 12'hFFF : 12'(ch * 12'h2A5);
    cmd(8'h08);
    codes("code after update");
    chk("simul kept", 16'(simul_mode), 16'h0001);
    $display("simultaneous test done");
  endtask

  // level lags the restrict state by one cycle, so wait two edges before looking
  task automatic t_restrict;
    cmd(8'h0F);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("restrict off", 16'(restrict_on), 16'h0000);
    for (int ch = 0; ch < 6; ch++)
      chk("full level", 16'(dac_level[ch]), 16'(exp_code[ch]));
    cmd(8'h0E);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("restrict on", 16'(restrict_on), 16'h0001);
    for (int ch = 0; ch < 6; ch++)
      chk("low level", 16'(dac_level[ch]), 16'((int'(exp_code[ch]) * 15) / 100));
    $display("restrict test done");
  endtask

  task automatic t_auto;
    cmd(8'h02);
    chk("auto", 16'(simul_mode), 16'h0000);
    codes("no update");
    acc(1'b1, 3'h2, 8'h02, 8'h34);
    chk("low only", 16'(dac_code[1]), 16'(exp_code[1]));
    acc(1'b1, 3'h2, 8'h03, 8'h0B);
    exp_code[1] = 12'hB34;
    chk("high commits", 16'(dac_code[1]), 16'hB34);
    cmd(8'h00);
    chk("simul again", 16'(simul_mode), 16'h0001);
    u_duc_host_model.put_code(2, 12'h000);
    chk("held", 16'(dac_code[2]), 16'(exp_code[2]));
    exp_code[2] = 12'h000;
    cmd(8'h0A);
    codes("update to auto");
    chk("auto after A", 16'(simul_mode), 16'h0000);
    u_duc_host_model.put_code(0, 12'h5C3);
    exp_code[0] = 12'h5C3;
    chk("auto high ch0", 16'(dac_code[0]), 16'h05C3);
    $display("auto test done");
  endtask

  task automatic t_regions;
    acc(1'b0, 3'h2, 8'h21, 8'h00);
    chk("dio read", {7'h00, ack, rd}, 16'h01A5);
    chk("dio pass", 16'(last_dio), 16'h0900);
    acc(1'b0, 3'h2, 8'h10, 8'h00);
    chk("reserved lo", {7'h00, ack, rd}, 16'h0100);
    acc(1'b0, 3'h2, 8'h3F, 8'h00);
    chk("reserved hi", {7'h00, ack, rd}, 16'h0100);
    chk("dio quiet", 16'(last_dio), 16'h0900);
    acc(1'b1, 3'h2, 8'h23, 8'h80);
    chk("dio write", 16'(last_dio), 16'h0F80);
    acc(1'b1, 3'h3, 8'hFF, 8'hC3);
    acc(1'b0, 3'h3, 8'hFF, 8'h00);
    chk("cal byte", {7'h00, ack, rd}, 16'h01C3);
    acc(1'b0, 3'h1, 8'h08, 8'h00);
    chk("other bar", 16'(ack), 16'h0000);
    $display("region test done");
  endtask

  // a second reset in mid-run must bring back the safe power-up state
  task automatic t_rerun;
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 reset = 1'b0;
    exp_code = '0;
    chk("simul after reset", 16'(simul_mode), 16'h0001);
    chk("restrict after reset", 16'(restrict_on), 16'h0001);
    codes("code after reset");
    chk("level after reset", 16'(dac_level[0]), 16'h0000);
    cmd(8'h0F);
    chk("release after reset", 16'(restrict_on), 16'h0000);
    $display("second reset test done");
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // guard against a hang; the full run needs about 80 cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      conclude();
    end
  end

  initial
  begin
    reset = 1'b1;
    dio_rdata = 8'hA5;
    repeat (10) @(posedge ref_clk);
    #1 reset = 1'b0;
    t_reset();
    t_simul();
    t_restrict();
    t_auto();
    t_regions();
    t_rerun();
    conclude();
  end
endmodule

`default_nettype wire
